// [core/uart_mode_config.sv]
`timescale 1ns/100ps
module uart_mode_config (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        sleep_i,
  input  wire logic        serial_receive_pin_i,
  output logic             serial_transmit_pin_o,
  output logic             irq_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] mode, next_mode, rate, next_rate, rate_cnt, next_rate_cnt;
  logic [6:0]  stat, next_stat, mask, next_mask, ev;
  logic [8:0]  rxd, next_rxd;
  logic        rx_full, next_rx_full, next_ack, next_pin;
  logic [31:0] next_dat;
  logic [4:0]  ir_cnt, next_ir_cnt;
  logic        prev_pin, prev_rx, armed, next_armed;
  logic        ab_run, next_ab_run;
  logic [2:0]  ab_falls, next_ab_falls;
  logic [23:0] ab_count, next_ab_count, ab_sh;
  logic [15:0] ab_rate;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic        access, wr, rd, tick, enable, loop, fast, ir_on;
  logic        pol_pin, ir_dec, rx_line, fall_pin, rise_pin, fall_rx;
  logic        nine, par_en, odd, tx_start, rd_rxd, ab_end;
  logic [1:0]  fmt;
  logic [15:0] clr, mask_wr;
  logic        tx_line, tx_busy, tx_done, rx_valid, rx_perr, rx_ferr, rx_idle;
  logic [3:0]  tx_phase;
  logic [8:0]  rx_data;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel);
    return {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  assign access  = cyc_i && stb_i && !ack_o;
  assign wr      = access && we_i;
  assign rd      = access && !we_i;
  assign enable  = mode[uart_pkg::b_enable];
  assign loop    = mode[uart_pkg::b_loop];
  assign fast    = mode[uart_pkg::b_fast];
  assign fmt     = mode[uart_pkg::b_fmt_lo +: 2];
  assign nine    = (fmt == uart_pkg::fmt_nine);
  assign par_en  = (fmt == uart_pkg::fmt_odd) || (fmt == uart_pkg::fmt_even);
  assign odd     = (fmt == uart_pkg::fmt_odd);
  // high-speed prescale would leave too few ticks per pulse to decode
  assign ir_on   = mode[uart_pkg::b_infrared] && !fast;
  assign tick    = (rate_cnt == 16'h0000);
  assign pol_pin = serial_receive_pin_i ^ mode[uart_pkg::b_rx_pol];
  assign ir_dec  = pol_pin && (ir_cnt == 5'h00);
  // loopback bypasses polarity and codec, the line is ours end to end
  assign rx_line = loop ? tx_line : (ir_on ? ir_dec : pol_pin);
  assign fall_pin = prev_pin && !pol_pin;
  assign rise_pin = !prev_pin && pol_pin;
  assign fall_rx  = prev_rx && !rx_line;
  assign tx_start = wr && adr_i == uart_pkg::adr_txd && sel_i[0] && enable && !tx_busy;
  assign rd_rxd   = rd && adr_i == uart_pkg::adr_rxd;
  assign clr      = (wr && adr_i == uart_pkg::adr_stat) ? merge(16'h0000, dat_i, sel_i)
                                                        : 16'h0000;
  assign ab_end   = ab_run && fall_rx && ab_falls == uart_pkg::sync_inner;
  assign ab_sh    = (ab_count + 24'h00_0001) >> (fast ? uart_pkg::sync_sh_fast
                                                      : uart_pkg::sync_sh_std);
  assign ab_rate  = (ab_sh == 24'h00_0000) ? 16'h0000 : ab_sh[15:0] - 16'h0001;
  assign mask_wr  = merge({9'h000, mask}, dat_i, sel_i);
  assign irq_o    = |(stat & mask);

  // ---------------------------------------------------------------
  // bus, registers and events
  // ---------------------------------------------------------------
  always_comb begin
    next_ack      = access;
    next_dat      = dat_o;
    next_mode     = mode;
    next_rate     = rate;
    next_mask     = mask;
    next_rxd      = rxd;
    next_armed    = armed;
    next_ab_run   = ab_run;
    next_ab_falls = ab_falls;
    next_ab_count = ab_count;
    ev            = 7'h00;
    if (rd) begin
      case (adr_i)
        uart_pkg::adr_mode: next_dat = {16'h0000, mode};
        uart_pkg::adr_rxd:  next_dat = {23'h00_0000, rxd};
        uart_pkg::adr_stat: next_dat = {21'h00_0000, rx_idle, rx_full, tx_busy, 1'b0, stat};
        uart_pkg::adr_mask: next_dat = {25'h000_0000, mask};
        uart_pkg::adr_rate: next_dat = {16'h0000, rate};
        default:            next_dat = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (adr_i)
        uart_pkg::adr_mode: next_mode = merge(mode, dat_i, sel_i) & uart_pkg::mode_write_mask;
        uart_pkg::adr_mask: next_mask = mask_wr[6:0];
        uart_pkg::adr_rate: next_rate = merge(rate, dat_i, sel_i);
        default:            next_mask = mask;
      endcase
    end
    // wake: armed by a start edge in sleep, released by the next rise
    if (mode[uart_pkg::b_wake] && sleep_i && fall_pin) begin
      ev[uart_pkg::s_wake] = 1'b1;
      next_armed           = 1'b1;
    end
    if (armed && rise_pin) begin
      next_mode[uart_pkg::b_wake] = 1'b0;
      next_armed                  = 1'b0;
    end
    if (!mode[uart_pkg::b_wake]) next_armed = 1'b0;
    // autobaud: 0x55 gives five falls across eight bit times
    if (!mode[uart_pkg::b_autobaud]) begin
      next_ab_run = 1'b0;
    end else if (!ab_run) begin
      if (fall_rx) begin
        next_ab_run   = 1'b1;
        next_ab_count = 24'h00_0000;
        next_ab_falls = 3'h0;
      end
    end else begin
      next_ab_count = ab_count + 24'h00_0001;
      if (fall_rx) next_ab_falls = ab_falls + 3'h1;
      if (ab_end) begin
        next_rate                       = ab_rate;
        next_mode[uart_pkg::b_autobaud] = 1'b0;
        next_ab_run                     = 1'b0;
        ev[uart_pkg::s_baud]            = 1'b1;
      end
    end
    if (rx_valid) begin
      next_rxd                = rx_data;
      ev[uart_pkg::s_rx_done] = 1'b1;
      ev[uart_pkg::s_parity]  = rx_perr;
      ev[uart_pkg::s_frame]   = rx_ferr;
      ev[uart_pkg::s_overrun] = rx_full && !rd_rxd;
    end
    ev[uart_pkg::s_tx_done] = tx_done;
    // a new event beats a software clear in the same cycle
    next_stat     = (stat & ~clr[6:0]) | ev;
    next_rx_full  = (rx_full && !rd_rxd) || rx_valid;
  end

  // ---------------------------------------------------------------
  // line side: prescale tick, codec, pins
  // ---------------------------------------------------------------
  always_comb begin
    next_rate_cnt = tick ? rate : rate_cnt - 16'h0001;
    if (!pol_pin) begin
      next_ir_cnt = uart_pkg::ir_hold_ticks;
    end else if (tick && ir_cnt != 5'h00) begin
      next_ir_cnt = ir_cnt - 5'h01;
    end else begin
      next_ir_cnt = ir_cnt;
    end
    if (!enable || loop) begin
      next_pin = 1'b1;
    end else if (ir_on) begin
      next_pin = !tx_line && (tx_phase < uart_pkg::ir_pulse_ticks);
    end else begin
      next_pin = tx_line;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ack_o                 <= 1'b0;
      dat_o                 <= 32'h0000_0000;
      mode                  <= uart_pkg::mode_reset;
      rate                  <= uart_pkg::rate_reset;
      rate_cnt              <= 16'h0000;
      mask                  <= 7'h00;
      stat                  <= 7'h00;
      rxd                   <= 9'h000;
      rx_full               <= 1'b0;
      ir_cnt                <= 5'h00;
      prev_pin              <= 1'b1;
      prev_rx               <= 1'b1;
      armed                 <= 1'b0;
      ab_run                <= 1'b0;
      ab_falls              <= 3'h0;
      ab_count              <= 24'h00_0000;
      serial_transmit_pin_o <= 1'b1;
    end else begin
      ack_o                 <= next_ack;
      dat_o                 <= next_dat;
      mode                  <= next_mode;
      rate                  <= next_rate;
      rate_cnt              <= next_rate_cnt;
      mask                  <= next_mask;
      stat                  <= next_stat;
      rxd                   <= next_rxd;
      rx_full               <= next_rx_full;
      ir_cnt                <= next_ir_cnt;
      prev_pin              <= pol_pin;
      prev_rx               <= rx_line;
      armed                 <= next_armed;
      ab_run                <= next_ab_run;
      ab_falls              <= next_ab_falls;
      ab_count              <= next_ab_count;
      serial_transmit_pin_o <= next_pin;
    end
  end

  // ---------------------------------------------------------------
  // shifters
  // ---------------------------------------------------------------
  serial_tx tx_unit (
    .clock_i    (clock_i),
    .resetn_i   (resetn_i),
    .tick_i     (tick),
    .fast_i     (fast),
    .start_i    (tx_start),
    .data_i     (dat_i[8:0]),
    .nine_i     (nine),
    .par_en_i   (par_en),
    .odd_i      (odd),
    .two_stop_i (mode[uart_pkg::b_stop]),
    .line_o     (tx_line),
    .phase_o    (tx_phase),
    .busy_o     (tx_busy),
    .done_o     (tx_done)
  );

  // receiver is held off while the rate is being measured
  serial_rx rx_unit (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .tick_i   (tick),
    .fast_i   (fast),
    .enable_i (enable && !mode[uart_pkg::b_autobaud]),
    .line_i   (rx_line),
    .nine_i   (nine),
    .par_en_i (par_en),
    .odd_i    (odd),
    .data_o   (rx_data),
    .valid_o  (rx_valid),
    .perr_o   (rx_perr),
    .ferr_o   (rx_ferr),
    .idle_o   (rx_idle)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_wake_event: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (mode[uart_pkg::b_wake] && sleep_i && fall_pin) |=> stat[uart_pkg::s_wake] && armed)
    else $error("sleep start edge did not flag wake");

  a_wake_clear: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (armed && rise_pin) |=> !mode[uart_pkg::b_wake] && !armed)
    else $error("wake enable not cleared on rising edge");

  a_loop_feed: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    loop |-> (rx_line == tx_line) && serial_transmit_pin_o == 1'b1 ##1 1'b1)
    else $error("loopback not routing transmitter to receiver");

  a_idle_polarity: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (!loop && !ir_on) |-> rx_line == (serial_receive_pin_i ^ mode[uart_pkg::b_rx_pol]))
    else $error("receive idle polarity wrong");

  a_frame_map: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (nine == (fmt == uart_pkg::fmt_nine)) && (odd == (fmt == uart_pkg::fmt_odd))
      && (par_en == (fmt[0] ^ fmt[1])))
    else $error("frame format decode wrong");

  a_ir_std_only: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (fast && enable && !loop) |=> serial_transmit_pin_o == $past(tx_line))
    else $error("codec active in high-speed mode");

  a_autobaud_done: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    ab_end |=> !mode[uart_pkg::b_autobaud] && rate == $past(ab_rate)
              && stat[uart_pkg::s_baud])
    else $error("autobaud did not load rate and clear");
endmodule

// [core/uart_pkg.sv]
package uart_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] adr_mode = 8'h00;
  localparam logic [7:0] adr_txd  = 8'h04;
  localparam logic [7:0] adr_rxd  = 8'h08;
  localparam logic [7:0] adr_stat = 8'h0c;
  localparam logic [7:0] adr_mask = 8'h10;
  localparam logic [7:0] adr_rate = 8'h14;

  // ---------------------------------------------------------------
  // serial_mode_register fields
  // ---------------------------------------------------------------
  localparam int b_enable   = 15;
  localparam int b_infrared = 12;
  localparam int b_wake     = 7;
  localparam int b_loop     = 6;
  localparam int b_autobaud = 5;
  localparam int b_rx_pol   = 4;
  localparam int b_fast     = 3;
  localparam int b_fmt_lo   = 1;
  localparam int b_stop     = 0;
  localparam logic [15:0] mode_write_mask = 16'hbbff;
  localparam logic [15:0] mode_reset      = 16'h0000;
  localparam logic [15:0] rate_reset      = 16'h0000;
  localparam logic [1:0]  fmt_nine        = 2'b11;
  localparam logic [1:0]  fmt_odd         = 2'b10;
  localparam logic [1:0]  fmt_even        = 2'b01;

  // ---------------------------------------------------------------
  // status bits
  // ---------------------------------------------------------------
  localparam int s_rx_done  = 0;
  localparam int s_tx_done  = 1;
  localparam int s_parity   = 2;
  localparam int s_frame    = 3;
  localparam int s_overrun  = 4;
  localparam int s_wake     = 5;
  localparam int s_baud     = 6;
  localparam int s_width    = 7;

  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  localparam logic [3:0] last_fast      = 4'h3;
  localparam logic [3:0] last_std       = 4'hf;
  localparam logic [3:0] half_fast      = 4'h1;
  localparam logic [3:0] half_std       = 4'h7;
  localparam logic [3:0] ir_pulse_ticks = 4'h3;
  localparam logic [4:0] ir_hold_ticks  = 5'h10;
  localparam logic [2:0] sync_inner     = 3'h3;
  localparam int         sync_sh_fast   = 5;
  localparam int         sync_sh_std    = 7;

  function automatic logic [3:0] last_phase(input logic fast);
    return fast ? last_fast : last_std;
  endfunction
endpackage

// [core/serial_tx.sv]
`timescale 1ns/100ps
module serial_tx (
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       tick_i,
  input  wire logic       fast_i,
  input  wire logic       start_i,
  input  wire logic [8:0] data_i,
  input  wire logic       nine_i,
  input  wire logic       par_en_i,
  input  wire logic       odd_i,
  input  wire logic       two_stop_i,
  output logic            line_o,
  output logic [3:0]      phase_o,
  output logic            busy_o,
  output logic            done_o
);
  typedef enum logic [2:0] {
    tx_idle  = 3'b000,
    tx_start = 3'b001,
    tx_data  = 3'b010,
    tx_par   = 3'b011,
    tx_stop  = 3'b100
  } tx_state_type;

  tx_state_type state, next_state;
  logic [8:0]   shift, next_shift;
  logic [3:0]   phase, next_phase, bits, next_bits;
  logic         par, next_par, stops, next_stops;
  logic         next_line, next_done, bit_end;

  assign bit_end = tick_i && (phase == uart_pkg::last_phase(fast_i));
  assign phase_o = phase;
  assign busy_o  = (state != tx_idle);

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_phase = phase;
    next_bits  = bits;
    next_par   = par;
    next_stops = stops;
    next_done  = 1'b0;
    if (state != tx_idle && tick_i) begin
      next_phase = bit_end ? 4'h0 : phase + 4'h1;
    end
    case (state)
      tx_idle: begin
        if (start_i) begin
          next_state = tx_start;
          next_shift = data_i;
          next_phase = 4'h0;
          next_bits  = nine_i ? 4'h8 : 4'h7;
          next_par   = (^data_i[7:0]) ^ odd_i;
        end
      end
      tx_start: begin
        if (bit_end) next_state = tx_data;
      end
      tx_data: begin
        if (bit_end) begin
          next_shift = {1'b0, shift[8:1]};
          next_bits  = bits - 4'h1;
          if (bits == 4'h0) begin
            next_state = par_en_i ? tx_par : tx_stop;
            next_stops = two_stop_i;
          end
        end
      end
      tx_par: begin
        if (bit_end) next_state = tx_stop;
      end
      tx_stop: begin
        if (bit_end) begin
          if (stops) begin
            next_stops = 1'b0;
          end else begin
            next_state = tx_idle;
            next_done  = 1'b1;
          end
        end
      end
      default: next_state = tx_idle;
    endcase
    case (next_state)
      tx_start: next_line = 1'b0;
      tx_data:  next_line = next_shift[0];
      tx_par:   next_line = next_par;
      default:  next_line = 1'b1;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state  <= tx_idle;
      shift  <= 9'h000;
      phase  <= 4'h0;
      bits   <= 4'h0;
      par    <= 1'b0;
      stops  <= 1'b0;
      line_o <= 1'b1;
      done_o <= 1'b0;
    end else begin
      state  <= next_state;
      shift  <= next_shift;
      phase  <= next_phase;
      bits   <= next_bits;
      par    <= next_par;
      stops  <= next_stops;
      line_o <= next_line;
      done_o <= next_done;
    end
  end

  a_bit_length: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (state != tx_idle) |-> (phase <= (fast_i ? uart_pkg::last_fast : uart_pkg::last_std)))
    else $error("tx bit phase beyond prescale length");

  a_parity_slot: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (state == tx_data && bit_end && bits == 4'h0)
      |=> (state == (par_en_i ? tx_par : tx_stop)))
    else $error("tx parity slot not as framed");

  a_stop_count: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (state == tx_stop && bit_end && !stops) |=> (state == tx_idle && done_o))
    else $error("tx frame did not end after last stop bit");
endmodule

// [core/serial_rx.sv]
`timescale 1ns/100ps
module serial_rx (
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       tick_i,
  input  wire logic       fast_i,
  input  wire logic       enable_i,
  input  wire logic       line_i,
  input  wire logic       nine_i,
  input  wire logic       par_en_i,
  input  wire logic       odd_i,
  output logic [8:0]      data_o,
  output logic            valid_o,
  output logic            perr_o,
  output logic            ferr_o,
  output logic            idle_o
);
  typedef enum logic [2:0] {
    rx_idle  = 3'b000,
    rx_start = 3'b001,
    rx_data  = 3'b010,
    rx_par   = 3'b011,
    rx_stop  = 3'b100
  } rx_state_type;

  rx_state_type state, next_state;
  logic [8:0]   shift, next_shift, next_data;
  logic [3:0]   phase, next_phase, bits, next_bits;
  logic         next_valid, next_perr, next_ferr, sample;

  // sample at bit centre: half a bit after the start edge, then every bit
  assign sample = tick_i && (phase == uart_pkg::last_phase(fast_i));
  assign idle_o = (state == rx_idle);

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_phase = phase;
    next_bits  = bits;
    next_data  = data_o;
    next_perr  = perr_o;
    next_ferr  = ferr_o;
    next_valid = 1'b0;
    if (state != rx_idle && tick_i) next_phase = phase + 4'h1;
    case (state)
      rx_idle: begin
        if (!line_i) begin
          next_state = rx_start;
          next_phase = 4'h0;
          next_bits  = nine_i ? 4'h8 : 4'h7;
          next_perr  = 1'b0;
        end
      end
      rx_start: begin
        if (tick_i && phase == (fast_i ? uart_pkg::half_fast : uart_pkg::half_std)) begin
          next_phase = 4'h0;
          next_state = line_i ? rx_idle : rx_data;
        end
      end
      rx_data: begin
        if (sample) begin
          next_phase = 4'h0;
          next_shift = {line_i, shift[8:1]};
          next_bits  = bits - 4'h1;
          if (bits == 4'h0) next_state = par_en_i ? rx_par : rx_stop;
        end
      end
      rx_par: begin
        if (sample) begin
          next_phase = 4'h0;
          next_perr  = line_i ^ (^shift[8:1]) ^ odd_i;
          next_state = rx_stop;
        end
      end
      rx_stop: begin
        if (sample) begin
          next_ferr  = ~line_i;
          next_valid = 1'b1;
          next_data  = nine_i ? shift : {1'b0, shift[8:1]};
          next_state = rx_idle;
        end
      end
      default: next_state = rx_idle;
    endcase
    if (!enable_i) next_state = rx_idle;
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state   <= rx_idle;
      shift   <= 9'h000;
      phase   <= 4'h0;
      bits    <= 4'h0;
      data_o  <= 9'h000;
      valid_o <= 1'b0;
      perr_o  <= 1'b0;
      ferr_o  <= 1'b0;
    end else begin
      state   <= next_state;
      shift   <= next_shift;
      phase   <= next_phase;
      bits    <= next_bits;
      data_o  <= next_data;
      valid_o <= next_valid;
      perr_o  <= next_perr;
      ferr_o  <= next_ferr;
    end
  end

  a_rx_parity: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && state == rx_data && sample && bits == 4'h0 && par_en_i)
      |=> (state == rx_par))
    else $error("rx skipped parity slot");
endmodule

// [bench/serial_node.sv]
`timescale 1ns/100ps
module serial_node (
  input  wire logic clock_i,
  input  wire logic inv_i,
  output logic      line_o
);
  logic level = 1'h1;
  // idle follows the polarity, so a polarity change alone is no start
  assign line_o = level ^ inv_i;
  task automatic send(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      level <= f[i];
      repeat (bt) @(posedge clock_i);
    end
  endtask
endmodule

// [bench/test_uart_mode_config.sv]
`timescale 1ns/100ps
module test_uart_mode_config;
  logic        clock = 0, resetn = 0, cyc = 0, stb = 0, we = 0, sleep = 0, inv = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rdat, q;
  logic        ack, rx_line, txp, irq;
  logic [8:0]  d;
  int          cnt;
  int          n_errors = 0, compares = 0, cycles = 0, seed = 32'h8b13ba37;
  always #20 clock = ~clock;
  uart_mode_config uut (.clock_i(clock), .resetn_i(resetn), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .sleep_i(sleep), .serial_receive_pin_i(rx_line), .serial_transmit_pin_o(txp),
    .irq_o(irq));
  serial_node node (.clock_i(clock), .inv_i(inv), .line_o(rx_line));
  task automatic complete_run;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      complete_run;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // one classic cycle; ack and data are taken at the edge they are seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= v;
    do begin
      @(posedge clock);
    end while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clock);
  endtask
  // fast cases run rate 3, so a wrong divisor shows as 64-clock bits
  task automatic tx_case(input int i);
    logic       b[$];
    logic [1:0] f;
    logic       fast;
    int         t;
    f = i[2:1];
    fast = i[1] ^ i[0];
    d = 9'($random(seed));
    b = {1'h0};
    for (int k = 0; k < (f == uart_pkg::fmt_nine ? 9 : 8); k++) b.push_back(d[k]);
    if (f == uart_pkg::fmt_odd || f == uart_pkg::fmt_even) b.push_back(^d[7:0] ^ f[1]);
    repeat (i[0] + 1) b.push_back(1'h1);
    wb(1'h1, uart_pkg::adr_rate, {30'h0, fast, fast});
    wb(1'h1, uart_pkg::adr_mode, 32'h0000_8000 | {28'h0, fast, f, i[0]});
    wb(1'h1, uart_pkg::adr_txd, {23'h0, d});
    for (t = 0; t < 9 && txp !== 1'h0; t++) @(posedge clock);
    repeat (8) @(posedge clock);
    foreach (b[k]) begin
      chk1(txp, b[k]);
      repeat (16) @(posedge clock);
    end
  endtask
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'h1;
    @(posedge clock);
    wb(1'h0, uart_pkg::adr_mode, 32'h0000_0000);
    chk(q, {16'h0, uart_pkg::mode_reset});
    wb(1'h0, 8'h20, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    $display("reset and map done");
    for (int i = 0; i < 8; i++) tx_case(i);
    $display("frames done");
    wb(1'h1, uart_pkg::adr_mask, 32'h0000_0001);
    wb(1'h1, uart_pkg::adr_mode, 32'h0000_8040);
    d = 9'($random(seed));
    wb(1'h1, uart_pkg::adr_txd, {23'h0, d});
    for (int t = 0; t < 400 && irq !== 1'h1; t++) @(posedge clock);
    chk1(txp, 1'h1);
    wb(1'h0, uart_pkg::adr_rxd, 32'h0000_0000);
    chk(q, {24'h0, d[7:0]});
    wb(1'h1, uart_pkg::adr_mask, 32'h0000_0000);
    chk1(irq, 1'h0);
    wb(1'h1, uart_pkg::adr_mask, 32'h0000_0001);
    chk1(irq, 1'h1);
    wb(1'h1, uart_pkg::adr_stat, 32'h0000_0001);
    chk1(irq, 1'h0);
    $display("loopback done");
    inv <= 1'h1;
    wb(1'h1, uart_pkg::adr_mode, 32'h0000_8010);
    d = 9'($random(seed));
    node.send(d[7:0], 16);
    wb(1'h0, uart_pkg::adr_rxd, 32'h0000_0000);
    chk(q, {24'h0, d[7:0]});
    $display("inversion done");
    inv <= 1'h0;
    sleep <= 1'h1;
    wb(1'h1, uart_pkg::adr_mode, 32'h0000_8080);
    wb(1'h0, uart_pkg::adr_mode, 32'h0000_0000);
    chk(q, 32'h0000_8080);
    node.send(8'h00, 16);
    sleep <= 1'h0;
    wb(1'h0, uart_pkg::adr_stat, 32'h0000_0000);
    chk1(q[uart_pkg::s_wake], 1'h1);
    wb(1'h0, uart_pkg::adr_mode, 32'h0000_0000);
    chk(q, 32'h0000_8000);
    $display("wake done");
    wb(1'h1, uart_pkg::adr_mode, 32'h0000_9008);
    chk1(txp, 1'h1);
    wb(1'h1, uart_pkg::adr_mode, 32'h0000_9000);
    chk1(txp, 1'h0);
    wb(1'h1, uart_pkg::adr_txd, 32'h0000_0000);
    cnt = 0;
    while (txp === 1'h1 && cnt < 20) begin
      @(posedge clock);
      cnt++;
    end
    chk(cnt, {28'h0, uart_pkg::ir_pulse_ticks});
    $display("infrared done");
    // sync of 32-clock bits at sixteen ticks per bit measures rate 1
    wb(1'h1, uart_pkg::adr_mode, 32'h0000_8020);
    node.send(8'h55, 32);
    wb(1'h0, uart_pkg::adr_rate, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    wb(1'h0, uart_pkg::adr_mode, 32'h0000_0000);
    chk(q, 32'h0000_8000);
    $display("autobaud done");
    complete_run;
  end
endmodule
